// ---- core/acdr_regs.v ----
// Behaviour
// - address bit 0 picks direction, 0 write, 1 read
// - only address 1101100x is answered, d8 write, d9 read
// - byte one bit 6 enables load diagnostic
// - byte one bit 5 enables offset detection
// - byte one bits 4 and 3 pick front and rear gain, 1 is 12db
// - byte one bits 2 and 1 unmute front and rear pairs
// - byte one bit 0 picks clip threshold, 1 is 10 percent
// - byte two bit 4 high leaves standby
// - byte two bit 3 picks line driver diagnostic thresholds
// - byte two bit 2 enables ac current diagnostic
// - a read returns four diagnostic bytes in fixed order
// - diagnostic byte one bit 7 shows thermal warning
// - diagnostic byte one bit 6 shows cycle terminated
// - diagnostic byte two bit 7 shows offset detection active
// - diagnostic byte two bit 6 shows ac sensor active
// - diagnostic byte three bits 7,6 echo standby and diagnostic enable
// - bits 5..0 of each byte hold lf, lr, rf, rr faults; byte four top bits read zero
// - channel bit 5 shows ac open load
// - channel bit 4 shows permanent versus turn-on diagnostic
// - channel bit 3 shows shorted load
// - channel bit 2 shows open load or excess offset
// - channel bits 1 and 0 show short to supply and to ground
// - after each read every diagnostic cycle restarts
`default_nettype none
`include "acdr_map.vh"
module acdr_regs (
  // clocking
  input wire clock,
  input wire rst,
  input wire ce,
  // byte link from the bus engine
  input wire frame_start,
  input wire frame_stop,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  output wire rx_ack,
  input wire tx_req,
  output reg [7:0] tx_byte,
  // amplifier status inputs
  input wire thermal_warn,
  input wire cycle_done,
  input wire [5:0] fault_left_front_channel,
  input wire [5:0] fault_left_rear_channel,
  input wire [5:0] fault_right_front_channel,
  input wire [5:0] fault_right_rear_channel,
  // amplifier controls
  output wire diag_enable,
  output wire offset_enable,
  output wire front_gain_low,
  output wire rear_gain_low,
  output wire front_unmute,
  output wire rear_unmute,
  output wire clip_detector_threshold,
  output wire amp_run,
  output wire line_driver_mode,
  output wire ac_enable,
  output reg diag_restart
);
  localparam [3:0] st_idle = 4'b0001;
  localparam [3:0] st_write = 4'b0010;
  localparam [3:0] st_read = 4'b0100;
  localparam [3:0] st_ignore = 4'b1000;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [1:0] count_reg;
  reg [1:0] count_next;
  reg first_reg;
  wire [7:0] instruction_byte_one;
  wire [7:0] instruction_byte_two;
  wire [5:0] held_lf;
  wire [5:0] held_lr;
  wire [5:0] held_rf;
  wire [5:0] held_rr;
  reg held_thermal_reg;
  reg held_done_reg;
  wire addr_match;
  wire load_one;
  wire load_two;
  wire [7:0] diagnostic_byte_lf;
  wire [7:0] diagnostic_byte_lr;
  wire [7:0] diagnostic_byte_rf;
  wire [7:0] diagnostic_byte_rr;

  assign addr_match = (rx_byte[7:1] == `ACDR_ADDR_HI);

  // ack address only when it matches; only the first two data bytes of a write are acked
  assign rx_ack = rx_valid && ((state_reg == st_idle && first_reg && addr_match) ||
    (state_reg == st_write && count_reg < `ACDR_WR_BYTES));

  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      st_idle: begin
        if (rx_valid && first_reg) begin
          if (!addr_match) begin
            state_next = st_ignore;
          end else if (rx_byte[`ACDR_DIR_BIT]) begin
            state_next = st_read;
          end else begin
            state_next = st_write;
          end
          count_next = 2'd0;
        end
      end
      st_write: begin
        if (rx_valid && count_reg < `ACDR_WR_BYTES) begin
          count_next = count_reg + 2'd1;
        end
      end
      st_read: begin
        if (tx_req && count_reg != `ACDR_RD_BYTES) begin
          count_next = count_reg + 2'd1;
        end
      end
      st_ignore: begin
        state_next = st_ignore;
      end
      default: begin
        state_next = st_idle;
      end
    endcase
    if (frame_start || frame_stop) begin
      state_next = st_idle;
      count_next = 2'd0;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= st_idle;
      count_reg <= 2'd0;
      first_reg <= 1'b0;
      diag_restart <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      count_reg <= count_next;
      if (frame_start) begin
        first_reg <= 1'b1;
      end else if (rx_valid) begin
        first_reg <= 1'b0;
      end
      // any read frame restarts all cycles when it ends, once only
      diag_restart <= (frame_stop || frame_start) && state_reg == st_read;
    end
  end

  assign load_one = rx_valid && state_reg == st_write && count_reg == 2'd0;
  assign load_two = rx_valid && state_reg == st_write && count_reg == 2'd1;

  // fixed-zero bits are stored as sent; master keeps them zero
  acdr_byte_reg u_ib1 (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .load(load_one),
    .din(rx_byte),
    .q(instruction_byte_one)
  );

  acdr_byte_reg u_ib2 (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .load(load_two),
    .din(rx_byte),
    .q(instruction_byte_two)
  );

  assign diag_enable = instruction_byte_one[`ACDR_IB1_DIAG_EN];
  assign offset_enable = instruction_byte_one[`ACDR_IB1_OFS_EN];
  assign front_gain_low = instruction_byte_one[`ACDR_IB1_FRONT_GAIN];
  assign rear_gain_low = instruction_byte_one[`ACDR_IB1_REAR_GAIN];
  assign front_unmute = instruction_byte_one[`ACDR_IB1_FRONT_UNMUTE];
  assign rear_unmute = instruction_byte_one[`ACDR_IB1_REAR_UNMUTE];
  assign clip_detector_threshold = instruction_byte_one[`ACDR_IB1_CLIP_THR];
  assign amp_run = instruction_byte_two[`ACDR_IB2_RUN];
  assign line_driver_mode = instruction_byte_two[`ACDR_IB2_LINE_MODE];
  assign ac_enable = instruction_byte_two[`ACDR_IB2_AC_EN];

  // snapshot at read address so all four bytes agree
  wire take;
  assign take = rx_valid && first_reg && addr_match && rx_byte[`ACDR_DIR_BIT];

  acdr_snap u_lf (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .take(take),
    .fault_in(fault_left_front_channel),
    .fault_q(held_lf)
  );

  acdr_snap u_lr (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .take(take),
    .fault_in(fault_left_rear_channel),
    .fault_q(held_lr)
  );

  acdr_snap u_rf (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .take(take),
    .fault_in(fault_right_front_channel),
    .fault_q(held_rf)
  );

  acdr_snap u_rr (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .take(take),
    .fault_in(fault_right_rear_channel),
    .fault_q(held_rr)
  );

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      held_thermal_reg <= 1'b0;
      held_done_reg <= 1'b0;
    end else if (ce && take) begin
      held_thermal_reg <= thermal_warn;
      held_done_reg <= cycle_done;
    end
  end

  // channel fields: ac, perm, short, open/offset, vcc, gnd
  assign diagnostic_byte_lf = {held_thermal_reg, held_done_reg, held_lf};
  assign diagnostic_byte_lr = {offset_enable, ac_enable, held_lr};
  // standby echo taken from the real standby bit
  assign diagnostic_byte_rf = {amp_run, diag_enable, held_rf};
  assign diagnostic_byte_rr = {2'b00, held_rr};

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_byte <= 8'h00;
    end else if (ce) begin
      if (take || (state_reg == st_read && !tx_req)) begin
        if (take) begin
          // snapshot lands on this same edge, so use the live inputs
          tx_byte <= {thermal_warn, cycle_done, fault_left_front_channel};
        end else if (count_reg == 2'd0) begin
          tx_byte <= diagnostic_byte_lf;
        end else if (count_reg == 2'd1) begin
          tx_byte <= diagnostic_byte_lr;
        end else if (count_reg == 2'd2) begin
          tx_byte <= diagnostic_byte_rf;
        end else begin
          tx_byte <= diagnostic_byte_rr;
        end
      end
    end
  end
endmodule // acdr_regs
`default_nettype wire

// ---- inc/acdr_map.vh ----
`ifndef ACDR_MAP_VH
`define ACDR_MAP_VH
// address byte
`define ACDR_ADDR_HI 7'h6c
`define ACDR_DIR_BIT 0
// instruction byte one fields
`define ACDR_IB1_DIAG_EN 6
`define ACDR_IB1_OFS_EN 5
`define ACDR_IB1_FRONT_GAIN 4
`define ACDR_IB1_REAR_GAIN 3
`define ACDR_IB1_FRONT_UNMUTE 2
`define ACDR_IB1_REAR_UNMUTE 1
`define ACDR_IB1_CLIP_THR 0
// instruction byte two fields
`define ACDR_IB2_RUN 4
`define ACDR_IB2_LINE_MODE 3
`define ACDR_IB2_AC_EN 2
// reset values
`define ACDR_IB1_RST 8'h00
`define ACDR_IB2_RST 8'h00
// counts
`define ACDR_WR_BYTES 2'd2
`define ACDR_RD_BYTES 2'd3
`endif

// ---- core/acdr_byte_reg.v ----
`default_nettype none
module acdr_byte_reg (
  // clocking
  input wire clock,
  input wire rst,
  input wire ce,
  // write
  input wire load,
  input wire [7:0] din,
  // value
  output reg [7:0] q
);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= 8'h00;
    end else if (ce && load) begin
      q <= din;
    end
  end
endmodule // acdr_byte_reg
`default_nettype wire

// ---- core/acdr_snap.v ----
`default_nettype none
module acdr_snap (
  // clocking
  input wire clock,
  input wire rst,
  input wire ce,
  // capture
  input wire take,
  input wire [5:0] fault_in,
  // held result
  output reg [5:0] fault_q
);
  // results frozen so a read returns the previous cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_q <= 6'h00;
    end else if (ce && take) begin
      fault_q <= fault_in;
    end
  end
endmodule // acdr_snap
`default_nettype wire

// ---- verif/acdr_regs_monitor.sv ----
`default_nettype none
module acdr_regs_monitor (
  // clocking
  input wire logic clock,
  input wire logic rst,
  // byte link
  input wire logic frame_start,
  input wire logic frame_stop,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_ack,
  input wire logic tx_req,
  input wire logic [7:0] tx_byte,
  // controls
  input wire logic diag_enable,
  input wire logic offset_enable,
  input wire logic front_gain_low,
  input wire logic rear_gain_low,
  input wire logic front_unmute,
  input wire logic rear_unmute,
  input wire logic clip_detector_threshold,
  input wire logic amp_run,
  input wire logic line_driver_mode,
  input wire logic ac_enable,
  input wire logic diag_restart
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic [6:0] ib1_f = rx_byte[6:0];
  wire logic [2:0] ib2_f = rx_byte[4:2];
  // ce is held high by the bench, so it is left out
  sequence s_addr;
    frame_start ##1 rx_valid;
  endsequence
  sequence s_wr;
    s_addr ##0 rx_byte == 8'hd8 ##1 rx_valid ##1 rx_valid;
  endsequence
  a_ack_own: assert property (s_addr ##0 rx_byte[7:1] == 7'h6c |-> rx_ack)
    else $error("own address not acked");
  a_nack_other: assert property (s_addr ##0 rx_byte[7:1] != 7'h6c |-> !rx_ack)
    else $error("foreign address acked");
  a_ib1_load: assert property (s_wr |=> {diag_enable, offset_enable, front_gain_low,
    rear_gain_low, front_unmute, rear_unmute, clip_detector_threshold} == $past(ib1_f, 2))
    else $error("byte one controls wrong");
  a_ib2_load: assert property (s_wr |=> {amp_run, line_driver_mode, ac_enable} == $past(ib2_f))
    else $error("byte two controls wrong");
  a_third_nack: assert property (s_wr ##1 rx_valid |-> !rx_ack)
    else $error("third write byte acked");
  a_tx_hold: assert property (tx_req |=> $stable(tx_byte))
    else $error("next byte came too early");
  a_restart_once: assert property (diag_restart |=> !diag_restart)
    else $error("restart longer than one cycle");
  a_restart_why: assert property (diag_restart |-> $past(frame_stop))
    else $error("restart without frame end");
endmodule // acdr_regs_monitor
`default_nettype wire

// ---- verif/acdr_master.sv ----
`default_nettype none
module acdr_master (
  // answers
  input wire logic clock,
  input wire logic rx_ack,
  input wire logic [7:0] tx_byte,
  // requests
  output logic frame_start,
  output logic frame_stop,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_req,
  // results, got toggles per result
  output logic got,
  output logic [8:0] got_val
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {frame_start, frame_stop, rx_valid, tx_req, got, rx_byte, got_val} = 22'h0;
  end
  task automatic note(input logic [8:0] v);
    got_val = v;
    got = ~got;
  endtask
  task automatic send(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_byte = b;
    #4 note({rx_ack, b});
    @(posedge clock) #1;
  endtask
  task automatic frame(input logic [7:0] a, input logic [23:0] d, input int nw, input int nr, input int gap);
    frame_start = 1'b1;
    @(posedge clock) #1;
    frame_start = 1'b0;
    send(a);
    for (int i = 0; i < nw; i++) send(d[23-8*i -: 8]);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte; // released: no stale byte
    for (int i = 0; i < nr; i++) begin
      repeat (gap) @(posedge clock) #1;
      note({1'b0, tx_byte});
      tx_req = 1'b1;
      @(posedge clock) #1;
      tx_req = 1'b0;
      @(posedge clock) #1;
    end
    frame_stop = 1'b1;
    @(posedge clock) #1;
    frame_stop = 1'b0;
  endtask
endmodule // acdr_master
`default_nettype wire

// ---- verif/acdr_regs_test.sv ----
`default_nettype none
module acdr_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst, ce;
  logic [25:0] st;
  logic [7:0] ib1, ib2;
  logic [8:0] exp_q[$];
  integer failures = 0, total_checks = 0, cycles = 0, seed = 32'hf3d0;
  wire logic thermal_warn, cycle_done, frame_start, frame_stop, rx_valid, rx_ack, tx_req, got, diag_restart;
  wire logic [5:0] fault_left_front_channel, fault_left_rear_channel;
  wire logic [5:0] fault_right_front_channel, fault_right_rear_channel;
  wire logic [7:0] rx_byte, tx_byte;
  wire logic [8:0] got_val;
  wire logic diag_enable, offset_enable, front_gain_low, rear_gain_low, front_unmute, rear_unmute;
  wire logic clip_detector_threshold, amp_run, line_driver_mode, ac_enable;
  assign {thermal_warn, cycle_done, fault_left_front_channel, fault_left_rear_channel} = st[25:12];
  assign {fault_right_front_channel, fault_right_rear_channel} = st[11:0];
  acdr_regs i_acdr_regs (.*);
  acdr_master i_acdr_master (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(got) begin
    if ($time > 0) begin
      total_checks++;
      if (exp_q.size() == 0 || got_val !== exp_q[0]) begin
        failures++;
        $display("BAD got_val expected %h seen %h", exp_q.size() ? exp_q[0] : 9'h0, got_val);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  task automatic rd(input int gap);
    exp_q.push_back({1'b1, 8'hd9});
    exp_q.push_back({1'b0, st[25:18]});
    exp_q.push_back({1'b0, ib1[5], ib2[2], st[17:12]});
    exp_q.push_back({1'b0, ib2[4], ib1[6], st[11:6]});
    exp_q.push_back({3'b000, st[5:0]});
    exp_q.push_back({3'b000, st[5:0]});
    fork
      i_acdr_master.frame(8'hd9, 24'h0, 0, 5, gap);
      begin
        repeat (3) @(posedge clock);
        #1 st = 26'($random(seed));
      end
    join
  endtask
  task automatic wr(input logic [7:0] a, input int nw);
    logic [7:0] n1, n2, n3;
    n1 = {1'b0, 7'($random(seed))};
    n2 = {3'b000, 3'($random(seed)), 2'b00};
    n3 = 8'($random(seed));
    exp_q.push_back({a == 8'hd8, a});
    exp_q.push_back({a == 8'hd8, n1});
    exp_q.push_back({a == 8'hd8, n2});
    if (nw == 3) exp_q.push_back({1'b0, n3});
    if (a == 8'hd8) {ib1, ib2} = {n1, n2};
    i_acdr_master.frame(a, {n1, n2, n3}, nw, 0, 0);
  endtask
  initial begin
    {rst, ce, st, ib1, ib2} = {2'b11, 42'h0};
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    rd(0);
    $display("reset readback done");
    for (int k = 0; k < 8; k++) begin
      wr(8'hd8, 2 + k % 2);
      rd(k % 4);
      rd(0);
    end
    $display("write and read loop done");
    wr(8'hda, 2);
    wr(8'h58, 3);
    rd(1);
    $display("foreign address test done");
    close_out();
  end
endmodule // acdr_regs_test
bind acdr_regs acdr_regs_monitor i_acdr_regs_monitor (.*);
`default_nettype wire
